// >>> hw/hfrts_sequencer.sv
// Transceive sequencer: serial register port, command decode, FIFO, calibration
// Functional notes
// - Reset gives power-down and default registers
// - Enable starts oscillator; stable raises interrupt
// - Short request and wake frames by command
// - End of transmission raises interrupt
// - After transmit, receive starts automatically
// - Receive end interrupt; FIFO count readable
// - Receive error or collision flagged
// - Transmit water level interrupt while sending
// - Receive water level interrupt while receiving
// - Peer mode needs mode bit, threshold
// - Peer transmit switches transmitter on itself
// - Target bit gives detector-only low power
// - External field raises peer event interrupt
// - Response avoidance aborts on sensed field
// - Initiator sends after initial avoidance
// - AM only type B or transparent am
// - Target equals measurement over one-point-depth
// - Peer commands need mode bit, oscillator
// - Mask commands need receiver enable
// - Calibration steps resistance until at or below target, or until the code reaches FF
`timescale 1ns/1ns
`default_nettype none
module hfrts_sequencer
  import hfrts_pkg::*;
#(
   parameter int INIT_GUARD = hfrts_pkg::INIT_GUARD_CYC
)
(
   // Clock, enable and reset
   input  wire logic              core_clk,
   input  wire logic              ce,
   input  wire logic              resetn,
   // Host serial port
   input  wire logic              spiClk,
   input  wire logic              spiSelN,
   input  wire logic              spiMosi,
   output logic                   spiMiso,
   output logic                   spiMisoOe,
   output logic                   hostInterrupt,
   // Front-end control pins
   input  wire logic              enPin,
   input  wire logic              oscStable,
   input  wire logic              extField,
   output logic                   oscEnable,
   output logic                   regEnable,
   output logic                   txOn,
   output logic                   rxOn,
   output logic                   amMode,
   output logic                   fieldDetEnable,
   output logic [7:0]             fieldThreshold,
   output logic [7:0]             drvLevel,
   // Converter
   output logic                   measureReq,
   input  wire logic              adcValid,
   input  wire logic [7:0]        adcData,
   // Framer
   output hfrts_pkg::hfrts_tx_t   txOut,
   input  wire logic              txTake,
   input  wire logic              txFrameDone,
   input  wire hfrts_pkg::hfrts_rx_t rxIn
);
   import hfrts_pkg::*;

   typedef struct packed {
      logic [4:0] cnt;
      logic [6:0] shIn;
      logic [7:0] hdr;
      logic [7:0] shOut;
      logic       oe;
   } hfrts_frame_t;

   typedef struct packed {
      hfrts_req_t req;
      logic       tog;
   } hfrts_link_t;

   typedef struct packed {
      hfrts_state_t st;
      logic [7:0]  opCtrl, mode, cfg5, depthCfg, fthr, txLenHi, txLenLo;
      logic [7:0]  wlTx, wlRx, irq, depthDisp, adcOut, drvNonMod;
      logic [7:0]  rdData, drvRes, target;
      logic [3:0]  sy1, sy2, sy3;
      logic        oscReady, rxMask, transp, wlPrev, measReq, host_interrupt;
      logic [15:0] txRemain;
      logic [17:0] guard;
      logic [4:0]  wp, rp;
      logic [5:0]  cnt;
      logic        oscEn, txOn, rxOn, amMode, fdEn;
      hfrts_tx_t   tx;
   } hfrts_core_t;

   logic [1:0]   rstPipe;
   logic         rstN;
   hfrts_frame_t f, fn;
   hfrts_link_t  l, ln;
   hfrts_core_t  s, n;
   logic [7:0]   mem [FIFO_DEPTH];
   logic         push, pop, reqPulse;
   logic [7:0]   pushData, inB, rdv, clr;
   logic [13:0]  quot;
   logic [6:0]   den;
   wire          frameRst = spiSelN | ~rstN;

   // Reset release through two flops
   always_ff @(posedge core_clk or negedge resetn)
      if (!resetn)
         rstPipe <= 2'h0;
      else
         rstPipe <= {rstPipe[0], 1'b1};
   assign rstN = rstPipe[1];

   // Serial shifter; data sampled and shifted out on rising spiClk
   always_comb
   begin
      fn = f;
      ln = l;
      inB = {f.shIn, spiMosi};
      fn.oe = 1'b1;
      fn.shIn = inB[6:0];
      if (f.cnt != 5'h10)
         fn.cnt = f.cnt + 5'h01;
      fn.shOut = {f.shOut[6:0], 1'b0};
      if (f.cnt == 5'h07)
      begin
         fn.hdr = inB;
         if (inB[7:6] != OP_WR)
         begin
            ln.req = {inB, 8'h00};
            ln.tog = ~l.tog;
         end
      end
      // Read data is only taken after the host pause that follows byte 0
      if (f.cnt == 5'h08)
         fn.shOut = s.rdData;
      if (f.cnt == 5'h0F && f.hdr[7:6] == OP_WR)
      begin
         ln.req = {f.hdr, inB};
         ln.tog = ~l.tog;
      end
   end

   // Frame state clears whenever select is high
   always_ff @(posedge spiClk or posedge frameRst)
      if (frameRst)
         f <= '0;
      else
         f <= fn;

   // Request word and toggle survive between frames
   always_ff @(posedge spiClk or negedge rstN)
      if (!rstN)
         l <= '0;
      else
         l <= ln;

   assign spiMiso   = f.shOut[7];
   assign spiMisoOe = f.oe;

   // Target level: measurement divided by 1.depth_ratio_bit_msb..depth_ratio_bit_lsb
   assign den  = {1'b1, s.depthCfg[DEPTH_MSB:DEPTH_LSB]};
   assign quot = {adcData, 6'h00} / {7'h00, den};

   // Register read mux
   always_comb
   begin
      unique case (l.req.addr)
         A_OPCTRL: rdv = s.opCtrl;
         A_MODE:   rdv = s.mode;
         A_CFG5:   rdv = s.cfg5;
         A_DEPTH:  rdv = s.depthCfg;
         A_FTHR:   rdv = s.fthr;
         A_TXLEN1: rdv = s.txLenHi;
         A_TXLEN0: rdv = s.txLenLo;
         A_WLTX:   rdv = s.wlTx;
         A_WLRX:   rdv = s.wlRx;
         A_IRQ:    rdv = s.irq;
         A_FSTAT:  rdv = {2'h0, s.cnt};
         A_DDISP:  rdv = s.depthDisp;
         A_ADC:    rdv = s.adcOut;
         A_DRVNM:  rdv = s.drvNonMod;
         A_FIFO:   rdv = mem[s.rp];
         default:  rdv = 8'h00;
      endcase
   end

   // Core sequencer
   always_comb
   begin
      n = s;
      n.irq = 8'h00;   // Collects only this cycle's sets
      clr = 8'h00;
      push = 1'b0;
      pop = 1'b0;
      pushData = rxIn.data;
      n.measReq = 1'b0;
      n.sy1 = {extField, oscStable, enPin, l.tog};
      n.sy2 = s.sy1;
      n.sy3 = s.sy2;
      reqPulse = s.sy2[0] ^ s.sy3[0];
      n.oscEn = s.opCtrl[OP_EN] | s.sy2[1];
      if (!n.oscEn)
         n.oscReady = 1'b0;
      else if (s.sy2[2] && !s.oscReady)
      begin
         n.oscReady = 1'b1;
         n.irq[IRQ_OSC] = 1'b1;
      end
      // Field rising while detector runs
      if (s.fdEn && s.sy2[3] && !s.sy3[3])
         n.irq[IRQ_NFC] = 1'b1;
      // Host requests
      if (reqPulse)
      begin
         unique case (l.req.op)
            OP_WR:
            begin
               unique case (l.req.addr)
                  A_OPCTRL: n.opCtrl = l.req.data;
                  A_MODE:   n.mode = l.req.data;
                  A_CFG5:   n.cfg5 = l.req.data;
                  A_DEPTH:  n.depthCfg = l.req.data;
                  A_FTHR:   n.fthr = l.req.data;
                  A_TXLEN1: n.txLenHi = l.req.data;
                  A_TXLEN0: n.txLenLo = l.req.data;
                  A_WLTX:   n.wlTx = l.req.data;
                  A_WLRX:   n.wlRx = l.req.data;
                  A_DRVNM:  n.drvNonMod = l.req.data;
                  A_FIFO:
                  begin
                     push = (s.st != ST_RX) && (s.cnt != FIFO_FULL);
                     pushData = l.req.data;
                  end
                  default: ;
               endcase
            end
            OP_RD:
            begin
               n.rdData = rdv;
               if (l.req.addr == A_IRQ)
                  clr = s.irq;
               if (l.req.addr == A_FIFO)
                  pop = (s.cnt != 6'h00);
            end
            OP_CMD:
            begin
               unique case (l.req.addr)
                  CMD_CLEAR:
                  begin
                     n.wp = 5'h00;
                     n.rp = 5'h00;
                     n.cnt = 6'h00;
                     n.transp = 1'b0;
                  end
                  CMD_TXCRC, CMD_TXRAW:
                     if (s.oscReady)
                     begin
                        n.st = ST_TX;
                        n.txRemain = {s.txLenHi, s.txLenLo};
                        n.tx.crc = (l.req.addr == CMD_TXCRC);
                     end
                  CMD_REQA, CMD_WUPA:
                     if (s.oscReady)
                     begin
                        n.st = ST_TX;
                        n.txRemain = 16'h0000;
                        n.tx.short = (l.req.addr == CMD_REQA) ? SHORT_REQ : SHORT_WAKE;
                     end
                  CMD_NFCINIT, CMD_NFCRESP, CMD_NFCRESP0:
                     if (s.mode[MODE_NFC] && s.oscReady)
                     begin
                        n.st = ST_CA;
                        n.txRemain = {s.txLenHi, s.txLenLo};
                        n.tx.crc = 1'b1;
                        n.guard = (l.req.addr == CMD_NFCINIT) ?
                                  18'(INIT_GUARD - 1) : 18'(RESP_GUARD_CYC - 1);
                     end
                  CMD_MASKRX:
                     if (s.opCtrl[OP_RXEN])
                        n.rxMask = 1'b1;
                  CMD_UNMASKRX:
                     if (s.opCtrl[OP_RXEN])
                     begin
                        n.rxMask = 1'b0;
                        n.st = ST_RX;
                     end
                  CMD_TRANSP:
                     if (s.opCtrl[OP_RXEN] && s.opCtrl[OP_TXEN])
                        n.transp = 1'b1;
                  CMD_CALDEPTH:
                     if (s.oscReady && !s.depthCfg[DEPTH_SRC])
                     begin
                        n.st = ST_CAL0;
                        n.drvRes = s.drvNonMod;
                        n.measReq = 1'b1;
                     end
                  default: ;
               endcase
            end
            default: ;
         endcase
      end
      // Per-state behaviour
      unique case (s.st)
         ST_IDLE: ;
         ST_TX:
         begin
            if (s.tx.valid && txTake)
               n.tx.valid = 1'b0;
            else if (!s.tx.valid && s.txRemain != 16'h0000 && s.cnt != 6'h00 && !pop)
            begin
               n.tx.valid = 1'b1;
               n.tx.data = mem[s.rp];
               n.txRemain = s.txRemain - 16'h0001;
               pop = 1'b1;
            end
            if (txFrameDone)
            begin
               n.irq[IRQ_TXE] = 1'b1;
               n.st = ST_RX;
               n.rxMask = 1'b0;
               n.tx = '0;
            end
         end
         ST_RX:
            if (!s.rxMask)
            begin
               // Bytes arriving while full are lost and flagged
               if (rxIn.valid)
               begin
                  push = (s.cnt != FIFO_FULL);
                  if (s.cnt == FIFO_FULL)
                     n.irq[IRQ_ERR] = 1'b1;
               end
               if (rxIn.error)
                  n.irq[IRQ_ERR] = 1'b1;
               if (rxIn.collision)
                  n.irq[IRQ_COLL] = 1'b1;
               if (rxIn.done)
               begin
                  n.irq[IRQ_RXE] = 1'b1;
                  n.st = ST_IDLE;
               end
            end
         ST_CA:
            if (s.sy2[3])
            begin
               n.irq[IRQ_NFC] = 1'b1;
               n.st = ST_IDLE;
            end
            else if (s.guard == 18'h00000)
               n.st = ST_TX;
            else
               n.guard = s.guard - 18'h00001;
         ST_CAL0:
            if (adcValid)
            begin
               n.adcOut = adcData;
               n.target = quot[7:0];
               n.drvRes = s.drvRes + 8'h01;
               n.measReq = 1'b1;
               n.st = ST_CAL1;
            end
         ST_CAL1:
            if (adcValid)
            begin
               n.adcOut = adcData;
               // Stops at the weakest drive if target is never reached
               if (adcData <= s.target || s.drvRes == 8'hFF)
               begin
                  n.depthDisp = s.drvRes;
                  n.st = ST_IDLE;
               end
               else
               begin
                  n.drvRes = s.drvRes + 8'h01;
                  n.measReq = 1'b1;
               end
            end
      endcase
      // FIFO pointers and water levels
      if (push)
         n.wp = s.wp + 5'h01;
      if (pop)
         n.rp = s.rp + 5'h01;
      n.cnt = n.cnt + {5'h00, push} - {5'h00, pop};
      n.wlPrev = (s.st == ST_TX) ? ({2'h0, s.cnt} < s.wlTx && s.txRemain > {10'h000, s.cnt})
                                 : (s.st == ST_RX && {2'h0, s.cnt} > s.wlRx);
      if (n.wlPrev && !s.wlPrev)
         n.irq[IRQ_WL] = 1'b1;
      // A flag raised in the cycle it is read stays set
      n.irq = (s.irq & ~clr) | n.irq;
      n.host_interrupt = |n.irq;
      n.fdEn = n.opCtrl[OP_NFCT] | (n.st == ST_CA);
      n.txOn = n.opCtrl[OP_TXEN] | (n.mode[MODE_NFC] & (n.st == ST_TX))
               | (n.st == ST_CAL0) | (n.st == ST_CAL1);
      n.rxOn = (n.st == ST_RX) & ~n.rxMask;
      n.amMode = n.mode[MODE_ISOB] | (n.transp & n.cfg5[CFG5_AM]);
   end

   // Core registers; clock enable freezes them and the FIFO storage, not the serial port or reset flops
   always_ff @(posedge core_clk or negedge rstN)
      if (!rstN)
      begin
         s <= '0;
         s.st <= ST_IDLE;
      end
      else if (ce)
         s <= n;

   // FIFO storage
   always_ff @(posedge core_clk)
      if (ce && push)
         mem[s.wp] <= pushData;

   assign hostInterrupt  = s.host_interrupt;
   assign oscEnable      = s.oscEn;
   assign regEnable      = s.oscEn;
   assign txOn           = s.txOn;
   assign rxOn           = s.rxOn;
   assign amMode         = s.amMode;
   assign fieldDetEnable = s.fdEn;
   assign fieldThreshold = s.fthr;
   assign drvLevel       = s.drvRes;
   assign measureReq     = s.measReq;
   assign txOut          = s.tx;
endmodule
`default_nettype wire

// >>> common/hfrts_pkg.sv
// Constants, types and register map of the reader transceive sequencer
package hfrts_pkg;
   // Timing
   localparam int  CORE_MHZ       = 50;
   localparam real INIT_GUARD_MS  = 5.11;
   localparam int  INIT_GUARD_CYC = int'(INIT_GUARD_MS * 1000.0 * CORE_MHZ);
   localparam int  RESP_GUARD_CYC = 1024;
   // FIFO
   localparam int  FIFO_DEPTH = 32;
   localparam logic [5:0] FIFO_FULL = 6'h20;
   // Register indices
   localparam logic [5:0] A_OPCTRL = 6'h00;
   localparam logic [5:0] A_MODE   = 6'h01;
   localparam logic [5:0] A_CFG5   = 6'h02;
   localparam logic [5:0] A_DEPTH  = 6'h03;
   localparam logic [5:0] A_FTHR   = 6'h04;
   localparam logic [5:0] A_TXLEN1 = 6'h05;
   localparam logic [5:0] A_TXLEN0 = 6'h06;
   localparam logic [5:0] A_WLTX   = 6'h07;
   localparam logic [5:0] A_WLRX   = 6'h08;
   localparam logic [5:0] A_IRQ    = 6'h09;
   localparam logic [5:0] A_FSTAT  = 6'h0A;
   localparam logic [5:0] A_DDISP  = 6'h0B;
   localparam logic [5:0] A_ADC    = 6'h0C;
   localparam logic [5:0] A_DRVNM  = 6'h0D;
   localparam logic [5:0] A_FIFO   = 6'h3F;
   localparam logic [7:0] REG_RST  = 8'h00;
   // Field positions
   localparam int OP_EN = 7, OP_RXEN = 6, OP_TXEN = 3, OP_NFCT = 0;
   localparam int MODE_NFC = 7, MODE_ISOB = 0, CFG5_AM = 0;
   localparam int DEPTH_SRC = 7, DEPTH_MSB = 6, DEPTH_LSB = 1;
   localparam int IRQ_OSC = 7, IRQ_TXE = 6, IRQ_RXE = 5, IRQ_WL = 4;
   localparam int IRQ_ERR = 3, IRQ_COLL = 2, IRQ_NFC = 1;
   // Serial frame operations and direct commands
   localparam logic [1:0] OP_WR = 2'h0, OP_RD = 2'h1, OP_CMD = 2'h3;
   localparam logic [5:0] CMD_CLEAR = 6'h02, CMD_TXCRC = 6'h04, CMD_TXRAW = 6'h05;
   localparam logic [5:0] CMD_REQA = 6'h06, CMD_WUPA = 6'h07, CMD_NFCINIT = 6'h08;
   localparam logic [5:0] CMD_NFCRESP = 6'h09, CMD_NFCRESP0 = 6'h0A;
   localparam logic [5:0] CMD_MASKRX = 6'h10, CMD_UNMASKRX = 6'h11;
   localparam logic [5:0] CMD_TRANSP = 6'h12, CMD_CALDEPTH = 6'h1D;
   localparam logic [1:0] SHORT_REQ = 2'h1, SHORT_WAKE = 2'h2;

   typedef enum logic [5:0] {
      ST_IDLE = 6'h01, ST_TX = 6'h02, ST_RX = 6'h04,
      ST_CA = 6'h08, ST_CAL0 = 6'h10, ST_CAL1 = 6'h20
   } hfrts_state_t;

   typedef struct packed {
      logic [1:0] op;
      logic [5:0] addr;
      logic [7:0] data;
   } hfrts_req_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
      logic       crc;
      logic [1:0] short;
   } hfrts_tx_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
      logic       done;
      logic       error;
      logic       collision;
   } hfrts_rx_t;
endpackage

// >>> sim/hfrts_chk.sv
// Port-level concurrent checks for the transceive sequencer
`timescale 1ns/1ns
`default_nettype none
module hfrts_chk
   import hfrts_pkg::*;
#(
   parameter int INIT_GUARD = 50
)
(
   // Clock and reset
   input wire logic                  core_clk,
   input wire logic                  resetn,
   // Front end and host side
   input wire logic                  enPin,
   input wire logic                  extField,
   input wire logic                  hostInterrupt,
   input wire logic                  oscEnable,
   input wire logic                  txOn,
   input wire logic                  rxOn,
   input wire logic                  fieldDetEnable,
   input wire logic [7:0]            drvLevel,
   input wire logic                  measureReq,
   // Framer side
   input wire hfrts_pkg::hfrts_tx_t  txOut,
   input wire logic                  txTake,
   input wire logic                  txFrameDone,
   input wire hfrts_pkg::hfrts_rx_t  rxIn
);
   // One domain, so clocking and disable are shared
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!resetn);

   AST_PIN_WAKES: assert property (enPin [*5] |-> oscEnable)
      else $error("enable pin left the oscillator off");
   AST_TX_HOLD: assert property (txOut.valid && !txTake |=> txOut.valid && $stable(txOut.data))
      else $error("transmit byte dropped before it was taken");
   AST_TXEND_IRQ: assert property (txFrameDone |-> ##[1:3] hostInterrupt)
      else $error("no interrupt after end of transmission");
   AST_RX_START: assert property (txFrameDone |-> ##[1:2] rxOn)
      else $error("reception did not follow transmission");
   AST_RX_STOP: assert property (rxIn.done |-> ##[1:2] !rxOn)
      else $error("receiver still on after reception end");
   AST_RXEND_IRQ: assert property (rxIn.done |-> ##[1:3] hostInterrupt)
      else $error("no interrupt after end of reception");
   AST_ERR_IRQ: assert property (rxIn.error || rxIn.collision |-> ##[1:3] hostInterrupt)
      else $error("receive fault raised no interrupt");
   AST_TARGET_QUIET: assert property (fieldDetEnable && !oscEnable |-> !txOn && !rxOn)
      else $error("radio active in low power target state");
   AST_FIELD_IRQ: assert property ($rose(extField) && fieldDetEnable |-> ##[2:6] hostInterrupt)
      else $error("external field raised no interrupt");
   AST_MEAS_PULSE: assert property (measureReq |=> !measureReq)
      else $error("measure request longer than one cycle");
   AST_DRV_STEP: assert property ($changed(drvLevel) && drvLevel != 8'h00 |-> drvLevel == $past(drvLevel) + 8'h01)
      else $error("driver code did not step by one");
endmodule

bind hfrts_sequencer hfrts_chk #(.INIT_GUARD(INIT_GUARD)) i_chk (
   .core_clk(core_clk), .resetn(resetn), .enPin(enPin), .extField(extField),
   .hostInterrupt(hostInterrupt), .oscEnable(oscEnable), .txOn(txOn), .rxOn(rxOn),
   .fieldDetEnable(fieldDetEnable), .drvLevel(drvLevel), .measureReq(measureReq),
   .txOut(txOut), .txTake(txTake), .txFrameDone(txFrameDone), .rxIn(rxIn));
`default_nettype wire

// >>> sim/hfrts_host_model.sv
// Host controller model driving the serial register port
`timescale 1ns/1ns
`default_nettype none
module hfrts_host_model
   import hfrts_pkg::*;
(
   // Serial port toward the device
   output var logic  spiClk,
   output var logic  spiSelN,
   output var logic  spiMosi,
   input  wire logic spiMiso,
   input  wire logic spiMisoOe
);
   // Released data line idles high through its pull-up
   wire logic misoLine = spiMisoOe ? spiMiso : 1'b1;

   // Serial clock stands still between frames
   initial
   begin
      spiClk = 1'b0;
      spiSelN = 1'b1;
      spiMosi = 1'b0;
   end

   // One frame, MSB first; device samples on rising, host on falling edge
   task automatic xfer(input logic [1:0] op, input logic [5:0] a, input logic [7:0] d,
                       output logic [7:0] q);
      logic [15:0] sh;
      int          n;
      sh = {op, a, d};
      n = (op == OP_CMD) ? 8 : 16;
      q = 8'h00;
      spiSelN = 1'b0;
      #7;
      for (int i = 0; i < n; i++)
      begin
         if (i == 8)
            #120; // Core needs time to fetch read data
         spiMosi = sh[15 - i];
         #3 spiClk = 1'b1;
         #3 spiClk = 1'b0;
         if (i > 7)
            q = {q[6:0], misoLine};
      end
      #4 spiSelN = 1'b1;
      spiMosi = ~spiMosi; // Released line never repeats the last bit
      #200; // Keeps requests well apart
   endtask
endmodule
`default_nettype wire

// >>> sim/testbench.sv
// Self-checking bench for the transceive sequencer
`timescale 1ns/1ns
`default_nettype none
module testbench
   import hfrts_pkg::*;
;
   `define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin errors++; \
      $display("CHECK FAILED %s expected %0h seen %0h", n, e, a); end end

   // Bench-driven inputs
   logic       core_clk, resetn, enPin, oscStable, extField;
   logic       adcValid, txTake, txFrameDone;
   logic [7:0] adcData;
   hfrts_rx_t  rxIn;
   int         errors, total_checks;
   // Device outputs and serial lines
   wire logic  spiClk, spiSelN, spiMosi, spiMiso, spiMisoOe, hostInterrupt;
   wire logic  oscEnable, regEnable, txOn, rxOn, amMode, fieldDetEnable, measureReq;
   wire logic [7:0] fieldThreshold, drvLevel;
   wire hfrts_tx_t  txOut;

   // Short guard keeps the run brief
   hfrts_sequencer #(.INIT_GUARD(50)) i_hfrts_sequencer (
      .core_clk(core_clk), .ce(1'b1), .resetn(resetn), .spiClk(spiClk),
      .spiSelN(spiSelN), .spiMosi(spiMosi), .spiMiso(spiMiso), .spiMisoOe(spiMisoOe),
      .hostInterrupt(hostInterrupt), .enPin(enPin), .oscStable(oscStable),
      .extField(extField), .oscEnable(oscEnable), .regEnable(regEnable), .txOn(txOn),
      .rxOn(rxOn), .amMode(amMode), .fieldDetEnable(fieldDetEnable),
      .fieldThreshold(fieldThreshold), .drvLevel(drvLevel), .measureReq(measureReq),
      .adcValid(adcValid), .adcData(adcData), .txOut(txOut), .txTake(txTake),
      .txFrameDone(txFrameDone), .rxIn(rxIn));
   hfrts_host_model u_host (.spiClk(spiClk), .spiSelN(spiSelN), .spiMosi(spiMosi),
      .spiMiso(spiMiso), .spiMisoOe(spiMisoOe));

   // Core clock, 20 ns
   initial
   begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   // Register and handshake helpers
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      logic [7:0] q;
      u_host.xfer(OP_WR, a, d, q);
   endtask
   task automatic cmd(input logic [5:0] c);
      logic [7:0] q;
      u_host.xfer(OP_CMD, c, 8'h00, q);
   endtask
   task automatic rchk(input string n, input logic [5:0] a, input logic [7:0] e);
      logic [7:0] q;
      u_host.xfer(OP_RD, a, 8'h00, q);
      `CHK(n, e, q)
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic wait_tx;
      for (int i = 0; i < 40 && txOut.valid !== 1'b1; i++) @(posedge core_clk);
      if (txOut.valid !== 1'b1) errors++;
   endtask
   task automatic take;
      @(posedge core_clk) txTake <= 1'b1;
      @(posedge core_clk) txTake <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic tx_end;
      @(posedge core_clk) txFrameDone <= 1'b1;
      @(posedge core_clk) txFrameDone <= 1'b0;
      cyc(3);
   endtask
   task automatic rx_push(input hfrts_rx_t v);
      @(posedge core_clk) rxIn <= v;
      @(posedge core_clk) rxIn <= '0;
   endtask

   // Scenarios
   task automatic t_reset;
      rchk("opCtrl", A_OPCTRL, REG_RST);
      rchk("depthCfg", A_DEPTH, REG_RST);
      `CHK("oscEnable", 1'b0, oscEnable)
   endtask
   task automatic t_enable;
      @(posedge core_clk) enPin <= 1'b1;
      cyc(6);
      `CHK("pinWake", 1'b1, oscEnable)
      @(posedge core_clk) enPin <= 1'b0;
      cyc(6);
      wr(A_OPCTRL, 8'hC8);
      `CHK("regEnable", 1'b1, regEnable)
      @(posedge core_clk) oscStable <= 1'b1;
      cyc(8);
      `CHK("oscIrq", 1'b1, hostInterrupt)
      rchk("irqOsc", A_IRQ, 8'h80);
      `CHK("irqCleared", 1'b0, hostInterrupt)
   endtask
   task automatic t_short;
      for (int k = 0; k < 2; k++)
      begin
         cmd(k ? CMD_WUPA : CMD_REQA);
         `CHK("shortKind", k ? SHORT_WAKE : SHORT_REQ, txOut.short)
         take;
         tx_end;
         `CHK("rxAfterShort", 1'b1, rxOn)
         rx_push({1'b0, 8'h00, 3'b100});
         cyc(3);
         rchk("irqShort", A_IRQ, 8'h60);
      end
   endtask
   task automatic t_frame;
      wr(A_WLRX, 8'h04);
      cmd(CMD_CLEAR);
      wr(A_TXLEN1, 8'h00);
      wr(A_TXLEN0, 8'h02);
      wr(A_FIFO, 8'hA5);
      wr(A_FIFO, 8'h3C);
      cmd(CMD_TXCRC);
      wait_tx;
      `CHK("txByte0", 8'hA5, txOut.data)
      `CHK("txCrc", 1'b1, txOut.crc)
      take;
      wait_tx;
      `CHK("txByte1", 8'h3C, txOut.data)
      take;
      tx_end;
      `CHK("rxOn", 1'b1, rxOn)
      // Five bytes pass the water level of four
      for (int k = 0; k < 5; k++)
         rx_push({1'b1, 8'h10 + k[7:0], 3'b000});
      rx_push({1'b0, 8'h00, 3'b010});
      rx_push({1'b0, 8'h00, 3'b001});
      rx_push({1'b0, 8'h00, 3'b100});
      cyc(3);
      `CHK("rxOff", 1'b0, rxOn)
      rchk("fifoCount", A_FSTAT, 8'h05);
      rchk("fifoHead", A_FIFO, 8'h10);
      rchk("irqFrame", A_IRQ, 8'h7C);
   endtask
   task automatic t_mask;
      cmd(CMD_UNMASKRX);
      `CHK("unmask", 1'b1, rxOn)
      cmd(CMD_MASKRX);
      `CHK("mask", 1'b0, rxOn)
      wr(A_OPCTRL, 8'h88);
      cmd(CMD_UNMASKRX);
      `CHK("unmaskRefused", 1'b0, rxOn)
      wr(A_MODE, 8'h01);
      `CHK("amTypeB", 1'b1, amMode)
      wr(A_MODE, 8'h00);
      `CHK("ookDefault", 1'b0, amMode)
   endtask
   task automatic t_cal;
      logic [7:0] adc [3];
      adc = '{8'hC8, 8'hB4, 8'hA0};
      wr(A_DEPTH, 8'h1C);
      cmd(CMD_CALDEPTH);
      // Target 200*64/78 = 164: 180 steps on, 160 stops at code 2
      for (int k = 0; k < 3; k++)
      begin
         for (int i = 0; i < 40 && measureReq !== 1'b1; i++) @(posedge core_clk);
         adcValid <= 1'b1;
         adcData <= adc[k];
         @(posedge core_clk) adcValid <= 1'b0;
      end
      cyc(4);
      rchk("depthDisplay", A_DDISP, 8'h02);
   endtask
   task automatic t_peer;
      wr(A_OPCTRL, 8'hC0);
      wr(A_MODE, 8'h80);
      wr(A_FTHR, 8'h5A);
      `CHK("threshold", 8'h5A, fieldThreshold)
      cmd(CMD_CLEAR);
      wr(A_TXLEN0, 8'h01);
      wr(A_FIFO, 8'h77);
      cmd(CMD_NFCINIT);
      cyc(50);
      wait_tx;
      `CHK("peerTxOn", 1'b1, txOn)
      `CHK("peerByte", 8'h77, txOut.data)
      take;
      tx_end;
      // Field already present: response avoidance must give up
      @(posedge core_clk) extField <= 1'b1;
      cyc(4);
      cmd(CMD_NFCRESP);
      `CHK("respSuppressed", 1'b0, txOut.valid)
      rchk("irqPeer", A_IRQ, 8'h42);
      @(posedge core_clk) extField <= 1'b0;
   endtask
   task automatic t_target;
      @(posedge core_clk) oscStable <= 1'b0;
      wr(A_OPCTRL, 8'h01);
      `CHK("detectorOn", 1'b1, fieldDetEnable)
      `CHK("oscOff", 1'b0, oscEnable)
      @(posedge core_clk) extField <= 1'b1;
      cyc(8);
      `CHK("fieldIrq", 1'b1, hostInterrupt)
      rchk("irqField", A_IRQ, 8'h02);
      @(posedge core_clk) extField <= 1'b0;
   endtask

   // Verdict and end of run
   task automatic print_verdict;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // Reset, then the scenarios in order
   initial
   begin
      errors = 0;
      total_checks = 0;
      resetn = 1'b0;
      {enPin, oscStable, extField, adcValid, txTake, txFrameDone} = 6'h00;
      adcData = 8'h00;
      rxIn = '0;
      cyc(8);
      resetn <= 1'b1;
      cyc(6);
      t_reset;
      t_enable;
      t_short;
      t_frame;
      t_mask;
      t_cal;
      t_peer;
      t_target;
      print_verdict;
   end

   // Watchdog well beyond the expected run
   initial
   begin
      #300000;
      errors++;
      $display("watchdog expired");
      print_verdict;
   end
endmodule
`default_nettype wire
